/* rtl/mdsec_top.sv */
`timescale 1ns/1ps
`default_nettype none
module mdsec_top
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [15:0] core_addr,
  input  wire logic [7:0]  core_page,
  input  wire logic        core_psen_n,
  input  wire logic        core_rd_n,
  input  wire logic        core_wr_n,
  input  wire logic [7:0]  port_pins,
  input  wire logic [7:0]  gl_feedback,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        jtag_cmd_valid,
  input  wire logic [2:0]  jtag_cmd,
  input  wire logic [7:0]  jtag_arg,
  output logic             jtag_ack,
  output logic             jtag_refused,
  output logic             jtag_erase_pulse,
  output logic             jtag_flash_access_en,
  output logic             jtag_debug_en,
  output logic      [7:0]  main_sector_selects,
  output logic      [3:0]  secondary_segment_selects,
  output logic             sram_select,
  output logic             regblk_select,
  output logic      [7:0]  main_sector_wr_en,
  output logic      [3:0]  secondary_segment_wr_en
);

  // Configuration store; cleared to blank on reset in this model
  logic       security_r;
  logic       map_ok_r;
  logic [7:0] prot_main_r;
  logic [3:0] prot_seg_r;
  logic [1:0] viol_r;
  logic [1:0] viol_nxt;
  logic [7:0] pins_s1_r;
  logic [7:0] pins_s2_r;
  logic [7:0] rdata_r;
  logic       ack_r;
  logic       refused_r;
  logic       erase_r;

  mdsec_dec_if dif ();

  // Decoder sees the core bus and page directly [R15]
  assign dif.addr   = core_addr;
  assign dif.page   = core_page;
  assign dif.psen_n = core_psen_n;
  assign dif.rd_n   = core_rd_n;
  assign dif.wr_n   = core_wr_n;
  assign dif.map_ok = map_ok_r;

  mdsec_decode u_decode
  (
    .d (dif.dec)
  );

  // Selects stay combinational for zero added latency [R17]
  assign main_sector_selects       = dif.main_sel;
  assign secondary_segment_selects = dif.seg_sel;
  assign sram_select               = dif.sram_sel;
  assign regblk_select             = dif.regblk_sel;

  // Write gating: a protected sector never sees a write strobe [R5]
  wire core_wr = !core_wr_n;
  wire [7:0] main_wr_try = dif.main_hit & {8{core_wr}};
  wire [3:0] seg_wr_try  = dif.seg_sel & {4{core_wr}};
  assign main_sector_wr_en       = main_wr_try & ~prot_main_r;          // [R5]
  assign secondary_segment_wr_en = seg_wr_try & ~prot_seg_r;            // [R5]
  wire main_blocked = |(main_wr_try & prot_main_r);
  wire seg_blocked  = |(seg_wr_try & prot_seg_r);

  // JTAG command decode; secure device takes erase only [R1] [R2] [R3]
  wire cmd_take   = ce && jtag_cmd_valid;
  wire is_erase   = jtag_cmd == mdsec_pkg::CMD_ERASE_ALL;
  wire cmd_known  = jtag_cmd != 3'h7;
  wire cmd_ok     = cmd_known && (is_erase || !security_r);             // [R1] [R2] [R3]
  wire do_cmd     = cmd_take && cmd_ok;
  wire do_erase   = do_cmd && is_erase;
  wire do_mprot   = do_cmd && (jtag_cmd == mdsec_pkg::CMD_PROG_MAIN_PR);
  wire do_sprot   = do_cmd && (jtag_cmd == mdsec_pkg::CMD_PROG_SEG_PR);
  wire do_map     = do_cmd && (jtag_cmd == mdsec_pkg::CMD_PROG_MAP);
  wire do_secure  = do_cmd && (jtag_cmd == mdsec_pkg::CMD_SET_SECURITY);

  // Access enables drop the moment security is set [R1] [R2]
  assign jtag_flash_access_en = !security_r;                            // [R1]
  assign jtag_debug_en        = !security_r;                            // [R2]
  assign jtag_ack             = ack_r;
  assign jtag_refused         = refused_r;
  assign jtag_erase_pulse     = erase_r;

  // Configuration store: only JTAG writes it, erase wipes all [R4] [R6] [R14]
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      security_r  <= 1'b0;
      map_ok_r    <= 1'b0;
      prot_main_r <= mdsec_pkg::PROT_MAIN_RST;
      prot_seg_r  <= mdsec_pkg::PROT_SEG_RST;
    end
    else if (do_erase)
    begin
      security_r  <= 1'b0;                                              // [R4]
      map_ok_r    <= 1'b0;                                              // [R4]
      prot_main_r <= mdsec_pkg::PROT_MAIN_RST;                          // [R4]
      prot_seg_r  <= mdsec_pkg::PROT_SEG_RST;
    end
    else
    begin
      if (do_secure)
        security_r <= 1'b1;
      if (do_map)
        map_ok_r <= 1'b1;                                               // [R14]
      if (do_mprot)
        prot_main_r <= jtag_arg;                                        // [R6]
      if (do_sprot)
        prot_seg_r <= jtag_arg[3:0];                                    // [R6]
    end
  end

  // JTAG answer pulses, one cycle after the command
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ack_r     <= 1'b0;
      refused_r <= 1'b0;
      erase_r   <= 1'b0;
    end
    else if (ce)
    begin
      ack_r     <= do_cmd;
      refused_r <= jtag_cmd_valid && !cmd_ok;                           // [R3]
      erase_r   <= do_erase;                                            // [R4]
    end
  end

  // Blocked-write flags; set wins over a write-one clear
  wire viol_clr_wr = reg_wr && (reg_addr == mdsec_pkg::REG_VIOL);
  wire [1:0] viol_set = {seg_blocked, main_blocked};
  wire [1:0] viol_clr = viol_clr_wr ? reg_wdata[1:0] : 2'b00;
  assign viol_nxt = (viol_r & ~viol_clr) | viol_set;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      viol_r <= 2'b00;
    else if (ce)
      viol_r <= viol_nxt;
  end

  // Port pins come from outside; two flops before use [R15]
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pins_s1_r <= 8'h00;
      pins_s2_r <= 8'h00;
    end
    else if (ce)
    begin
      pins_s1_r <= port_pins;
      pins_s2_r <= pins_s1_r;
    end
  end

  // Read mux; protection registers are read-only by construction [R6]
  wire [7:0] status_w = {6'h00, map_ok_r, security_r};
  wire [7:0] rd_mux   =
    (reg_addr == mdsec_pkg::REG_PROT_MAIN) ? prot_main_r :                    // [R6]
    (reg_addr == mdsec_pkg::REG_PROT_SEG)  ? {4'h0, prot_seg_r} :             // [R6]
    (reg_addr == mdsec_pkg::REG_STATUS)    ? status_w :
    (reg_addr == mdsec_pkg::REG_VIOL)      ? {6'h00, viol_r} :
    (reg_addr == mdsec_pkg::REG_PINS)      ? pins_s2_r :
    (reg_addr == mdsec_pkg::REG_FEEDBACK)  ? gl_feedback :                    // [R15]
                                             mdsec_pkg::UNMAPPED_RD;

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rdata_r <= 8'h00;
    else if (ce)
      rdata_r <= reg_rd ? rd_mux : 8'h00;
  end
  assign reg_rdata = rdata_r;

  // Checks on security, protection and decode
  AST_SEC_REFUSE: assert property (@(posedge clock) disable iff (rst)   // [R3]
    (ce && jtag_cmd_valid && security_r && !is_erase) |=> (refused_r && !ack_r))
    else $error("secure device took a non-erase command");

  AST_SEC_NOPROG: assert property (@(posedge clock) disable iff (rst)   // [R1]
    (security_r && ce && jtag_cmd_valid && (jtag_cmd == mdsec_pkg::CMD_PROG_MAIN_PR))
      |=> $stable(prot_main_r))
    else $error("secure device accepted programming");

  AST_DEBUG_LOCK: assert property (@(posedge clock) disable iff (rst)   // [R2]
    security_r |-> (!jtag_debug_en && !jtag_flash_access_en))
    else $error("debug open while secure");

  AST_ERASE_BLANK: assert property (@(posedge clock) disable iff (rst)  // [R4]
    (ce && jtag_cmd_valid && is_erase) |=> (!security_r && !map_ok_r && prot_main_r == 8'h00
                                            && prot_seg_r == 4'h0 && erase_r))
    else $error("erase left device not blank");

  AST_PROT_GATE: assert property (@(posedge clock) disable iff (rst)    // [R5]
    (ce && core_wr && |(dif.main_hit & prot_main_r)) |=> viol_r[mdsec_pkg::VIOL_MAIN]
      && ((main_sector_wr_en & $past(prot_main_r)) == 8'h00 || !$past(core_wr)))
    else $error("protected sector write not blocked");

  AST_PROT_RO: assert property (@(posedge clock) disable iff (rst)      // [R6]
    (reg_wr && !jtag_cmd_valid) |=> ($stable(prot_main_r) && $stable(prot_seg_r) && $stable(map_ok_r)))
    else $error("core write changed protection or map");

  AST_RD_PROT: assert property (@(posedge clock) disable iff (rst)      // [R6]
    (ce && reg_rd && reg_addr == mdsec_pkg::REG_PROT_SEG) |=> (reg_rdata == {4'h0, $past(prot_seg_r)}))
    else $error("segment protect readback wrong");

  AST_COMMON_SECT: assert property (@(posedge clock) disable iff (rst)  // [R9]
    (map_ok_r && !core_psen_n && core_addr <= 16'h3fff) |-> (main_sector_selects == 8'h01))
    else $error("sector zero not selected");

  AST_PAGED_SECT: assert property (@(posedge clock) disable iff (rst)   // [R10]
    (map_ok_r && !core_psen_n && core_addr >= 16'hc000 && core_page == 8'h02)
      |-> (main_sector_selects == 8'h80))
    else $error("paged sector seven not selected");

  AST_SEG_SEL: assert property (@(posedge clock) disable iff (rst)      // [R11]
    (map_ok_r && !core_rd_n && core_addr >= 16'ha000 && core_addr <= 16'hbfff)
      |-> (secondary_segment_selects == 4'h2 && !sram_select))
    else $error("segment one not selected");

  AST_DATA_MAP: assert property (@(posedge clock) disable iff (rst)     // [R12]
    (map_ok_r && !core_wr_n && core_addr >= 16'h2000 && core_addr <= 16'h20ff)
      |-> (regblk_select && !sram_select))
    else $error("register block select wrong");

  AST_ONE_SEL: assert property (@(posedge clock) disable iff (rst)      // [R17]
    $onehot0({secondary_segment_selects, sram_select, regblk_select}) && $onehot0(main_sector_selects))
    else $error("more than one select");

  AST_QUAL: assert property (@(posedge clock) disable iff (rst)         // [R16]
    (core_psen_n |-> main_sector_selects == 8'h00) and
    ((core_rd_n && core_wr_n) |-> (secondary_segment_selects == 4'h0 && !sram_select)))
    else $error("select without strobe");

  // Clock enable low freezes stored state; checked on security, map, main protection, violation flags and read data
  AST_CE_FREEZE: assert property (@(posedge clock) disable iff (rst)    // [R14]
    !ce |=> ($stable(security_r) && $stable(map_ok_r) && $stable(prot_main_r) && $stable(viol_r)
             && $stable(reg_rdata)))
    else $error("state moved with clock enable low");

  AST_BLANK_DECODE: assert property (@(posedge clock) disable iff (rst) // [R14]
    !map_ok_r |-> (main_sector_selects == 8'h00 && secondary_segment_selects == 4'h0
                   && !sram_select && !regblk_select))
    else $error("blank device decoded an address");

  AST_PAGE0_SECT: assert property (@(posedge clock) disable iff (rst)   // [R10]
    (map_ok_r && !core_psen_n && core_addr >= 16'h8000 && core_addr <= 16'hbfff && core_page == 8'h00)
      |-> (main_sector_selects == 8'h04))
    else $error("paged sector two not selected");

  AST_SRAM_SEL: assert property (@(posedge clock) disable iff (rst)     // [R12]
    (map_ok_r && !core_rd_n && core_addr <= 16'h1fff)
      |-> (sram_select && !regblk_select && secondary_segment_selects == 4'h0))
    else $error("sram select wrong");

  AST_SEG_PROT: assert property (@(posedge clock) disable iff (rst)     // [R5]
    (ce && core_wr && |(dif.seg_sel & prot_seg_r))
      |-> (((secondary_segment_wr_en & prot_seg_r) == 4'h0) ##1 viol_r[mdsec_pkg::VIOL_SEG]))
    else $error("protected segment write not blocked");

  // Read data must fall back to zero outside its one cycle
  AST_RD_IDLE: assert property (@(posedge clock) disable iff (rst)      // [R6]
    (ce && !reg_rd) |=> (reg_rdata == 8'h00))
    else $error("read data outside its cycle");

  AST_PIN_SYNC: assert property (@(posedge clock) disable iff (rst)     // [R15]
    (ce && reg_rd && reg_addr == mdsec_pkg::REG_PINS) |=> (reg_rdata == $past(pins_s2_r)))
    else $error("pin readback not from second flop");

  AST_ANSWER: assert property (@(posedge clock) disable iff (rst)       // [R3]
    !(jtag_ack && jtag_refused) && (!jtag_erase_pulse || jtag_ack))
    else $error("conflicting command answers");

  COV_VIOL_CLEAR: cover property (@(posedge clock) disable iff (rst) viol_clr_wr && |viol_r);
  COV_ERASE_SECURE: cover property (@(posedge clock) disable iff (rst)
    security_r && ce && jtag_cmd_valid && is_erase);
  COV_REFUSED: cover property (@(posedge clock) disable iff (rst) refused_r);
  COV_BLOCKED: cover property (@(posedge clock) disable iff (rst) main_blocked || seg_blocked);
  COV_PAGED: cover property (@(posedge clock) disable iff (rst) main_sector_selects[5]);

endmodule
`default_nettype wire

/* rtl/mdsec_pkg.sv */
// Functional notes
// R1: Security set refuses JTAG programming of flash contents and logic configuration.
// R2: Security set also denies JTAG debug access to the core.
// R3: Security set: only whole-module erase is accepted over JTAG.
// R4: Whole-module erase clears security, protection and map, leaving device blank.
// R5: Per-sector write protect; core writes to protected sectors change nothing.
// R6: Protection status readable in two registers; core writes never change it.
// R7: Main flash decodes as eight 16 Kbyte sectors, one select each.
// R8: Secondary flash decodes as four 8 Kbyte segments, one select each.
// R9: Sectors zero and one cover 0000-3FFF and 4000-7FFF on every page.
// R10: Sectors two to seven paged over 8000-BFFF and C000-FFFF by page 0-2.
// R11: Segments zero to three cover 8000, A000, C000, E000 blocks, page-free.
// R12: SRAM select for 0000-1FFF, register block select for 2000-20FF.
// R13: External data selects ignore the core's internal RAM and special registers.
// R14: Address map is nonvolatile, loaded over JTAG, never changed by the core; this model clears it on reset.
// R15: Decode inputs: core address, strobes, page, port pins, logic feedback; the decoder here uses no port pins or feedback.
// R16: Main selects qualified by fetch strobe; data selects by read or write.
// R17: At most one select per address space; selects are combinational.
package mdsec_pkg;

  // Main flash map: index 7 leftmost
  localparam logic [7:0][15:0] MAIN_LO    = {16'hc000, 16'h8000, 16'hc000, 16'h8000,
                                             16'hc000, 16'h8000, 16'h4000, 16'h0000};
  localparam logic [7:0][15:0] MAIN_HI    = {16'hffff, 16'hbfff, 16'hffff, 16'hbfff,
                                             16'hffff, 16'hbfff, 16'h7fff, 16'h3fff};
  localparam logic [7:0][7:0]  MAIN_PAGE  = {8'h02, 8'h02, 8'h01, 8'h01,
                                             8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0]       MAIN_PAGED = 8'hfc;

  // Secondary flash segments
  localparam logic [3:0][15:0] SEG_LO = {16'he000, 16'hc000, 16'ha000, 16'h8000};
  localparam logic [3:0][15:0] SEG_HI = {16'hffff, 16'hdfff, 16'hbfff, 16'h9fff};

  // SRAM and register block
  localparam logic [15:0] SRAM_LO   = 16'h0000;
  localparam logic [15:0] SRAM_HI   = 16'h1fff;
  localparam logic [15:0] REGBLK_LO = 16'h2000;
  localparam logic [15:0] REGBLK_HI = 16'h20ff;

  // Register offsets
  localparam logic [7:0] REG_PROT_MAIN = 8'h00;
  localparam logic [7:0] REG_PROT_SEG  = 8'h01;
  localparam logic [7:0] REG_STATUS    = 8'h02;
  localparam logic [7:0] REG_VIOL      = 8'h03;
  localparam logic [7:0] REG_PINS      = 8'h04;
  localparam logic [7:0] REG_FEEDBACK  = 8'h05;

  // Field positions
  localparam int STAT_SECURE   = 0;
  localparam int STAT_MAP_OK   = 1;
  localparam int VIOL_MAIN     = 0;
  localparam int VIOL_SEG      = 1;

  // Reset (blank) values of the configuration store; read value of unmapped register offsets
  localparam logic [7:0] PROT_MAIN_RST = 8'h00;
  localparam logic [3:0] PROT_SEG_RST  = 4'h0;
  localparam logic [7:0] UNMAPPED_RD   = 8'h00;

  // JTAG command codes
  localparam logic [2:0] CMD_ERASE_ALL    = 3'h0;
  localparam logic [2:0] CMD_PROG_MAIN_PR = 3'h1;
  localparam logic [2:0] CMD_PROG_SEG_PR  = 3'h2;
  localparam logic [2:0] CMD_PROG_MAP     = 3'h3;
  localparam logic [2:0] CMD_SET_SECURITY = 3'h4;
  localparam logic [2:0] CMD_DEBUG        = 3'h5;
  localparam logic [2:0] CMD_FLASH_ACCESS = 3'h6;

endpackage

/* rtl/mdsec_dec_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mdsec_dec_if;
  logic [15:0] addr;
  logic [7:0]  page;
  logic        psen_n;
  logic        rd_n;
  logic        wr_n;
  logic        map_ok;
  logic [7:0]  main_hit;
  logic [7:0]  main_sel;
  logic [3:0]  seg_sel;
  logic        sram_sel;
  logic        regblk_sel;

  modport dec (input addr, page, psen_n, rd_n, wr_n, map_ok,
               output main_hit, main_sel, seg_sel, sram_sel, regblk_sel);
  modport top (output addr, page, psen_n, rd_n, wr_n, map_ok,
               input main_hit, main_sel, seg_sel, sram_sel, regblk_sel);
endinterface
`default_nettype wire

/* rtl/mdsec_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module mdsec_decode
(
  mdsec_dec_if.dec d
);

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  logic [7:0] main_raw;
  logic [3:0] seg_raw;
  logic       data_stb;

  // Main sectors: common pair plus paged six [R7] [R9] [R10]
  for (genvar i = 0; i < 8; i++)
  begin : g_main
    assign main_raw[i] = in_range(d.addr, mdsec_pkg::MAIN_LO[i], mdsec_pkg::MAIN_HI[i])
                         && (!mdsec_pkg::MAIN_PAGED[i] || (d.page == mdsec_pkg::MAIN_PAGE[i]));
  end

  // Secondary segments ignore page [R8] [R11]
  for (genvar j = 0; j < 4; j++)
  begin : g_seg
    assign seg_raw[j] = in_range(d.addr, mdsec_pkg::SEG_LO[j], mdsec_pkg::SEG_HI[j]);
  end

  // Blank device decodes nothing until the map is loaded [R14]
  assign data_stb     = !d.rd_n || !d.wr_n;
  assign d.main_hit   = d.map_ok ? main_raw : 8'h00;
  assign d.main_sel   = (d.map_ok && !d.psen_n) ? main_raw : 8'h00;                         // [R16] [R17]
  // Data space only; internal RAM and special registers play no part [R13]
  assign d.seg_sel    = (d.map_ok && data_stb) ? seg_raw : 4'h0;                             // [R16]
  assign d.sram_sel   = d.map_ok && data_stb
                        && in_range(d.addr, mdsec_pkg::SRAM_LO, mdsec_pkg::SRAM_HI);         // [R12]
  assign d.regblk_sel = d.map_ok && data_stb
                        && in_range(d.addr, mdsec_pkg::REGBLK_LO, mdsec_pkg::REGBLK_HI);     // [R12]

endmodule
`default_nettype wire

/* bench/mdsec_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mdsec_core_model
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [1:0]  req_kind,
  input  wire logic [15:0] req_addr,
  input  wire logic [7:0]  req_page,
  output logic      [15:0] core_addr,
  output logic      [7:0]  core_page,
  output logic             core_psen_n,
  output logic             core_rd_n,
  output logic             core_wr_n
);
  // Bus cycle launch; idle address flips so a decode cannot lean on stale lines
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      core_addr   <= 16'hffff;
      core_page   <= 8'h00;
      core_psen_n <= 1'b1;
      core_rd_n   <= 1'b1;
      core_wr_n   <= 1'b1;
    end
    else
    begin
      core_addr   <= (req_kind == 2'h0) ? ~core_addr : req_addr;
      core_page   <= req_page;
      core_psen_n <= (req_kind != 2'h1);
      core_rd_n   <= (req_kind != 2'h2);
      core_wr_n   <= (req_kind != 2'h3);
    end
  end
endmodule
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock, rst, ce, reg_wr, reg_rd, jv, ack, refused, erase, fl_en, dbg_en, sram_s, regb_s;
  logic [15:0] core_addr, req_addr;
  logic [7:0]  core_page, req_page, pins, fb, reg_addr, reg_wdata, rdata, jarg, msel, mwe;
  logic [3:0]  ssel, swe;
  logic [2:0]  jcmd_c;
  logic [1:0]  req_kind;
  logic [11:0] we_seen;
  logic        psen_n, rd_n, wr_n;
  int          fail_count, checked, i;
  // Rows: kind, address, page, main selects, segment selects, sram, register block
  logic [39:0] rows [0:23] = '{
    {2'h1, 16'h0000, 8'h00, 8'h01, 4'h0, 2'h0}, {2'h1, 16'h3fff, 8'h05, 8'h01, 4'h0, 2'h0},
    {2'h1, 16'h4000, 8'h02, 8'h02, 4'h0, 2'h0}, {2'h1, 16'h7fff, 8'h00, 8'h02, 4'h0, 2'h0},
    {2'h1, 16'h8000, 8'h00, 8'h04, 4'h0, 2'h0}, {2'h1, 16'hbfff, 8'h00, 8'h04, 4'h0, 2'h0},
    {2'h1, 16'hc000, 8'h00, 8'h08, 4'h0, 2'h0}, {2'h1, 16'h8000, 8'h01, 8'h10, 4'h0, 2'h0},
    {2'h1, 16'hffff, 8'h01, 8'h20, 4'h0, 2'h0}, {2'h1, 16'h8000, 8'h02, 8'h40, 4'h0, 2'h0},
    {2'h1, 16'hc000, 8'h02, 8'h80, 4'h0, 2'h0}, {2'h1, 16'h8000, 8'h03, 8'h00, 4'h0, 2'h0},
    {2'h2, 16'h8000, 8'h01, 8'h00, 4'h1, 2'h0}, {2'h2, 16'h9fff, 8'h00, 8'h00, 4'h1, 2'h0},
    {2'h3, 16'ha000, 8'h02, 8'h00, 4'h2, 2'h0}, {2'h2, 16'hdfff, 8'h00, 8'h00, 4'h4, 2'h0},
    {2'h2, 16'he000, 8'h07, 8'h00, 4'h8, 2'h0}, {2'h2, 16'hffff, 8'h00, 8'h00, 4'h8, 2'h0},
    {2'h2, 16'h0000, 8'h00, 8'h00, 4'h0, 2'h2}, {2'h3, 16'h1fff, 8'h00, 8'h00, 4'h0, 2'h2},
    {2'h2, 16'h2000, 8'h00, 8'h00, 4'h0, 2'h1}, {2'h2, 16'h20ff, 8'h00, 8'h00, 4'h0, 2'h1},
    {2'h2, 16'h2100, 8'h00, 8'h00, 4'h0, 2'h0}, {2'h1, 16'h2000, 8'h00, 8'h01, 4'h0, 2'h0}};

  mdsec_core_model i_mdsec_core_model (.clock(clock), .rst(rst), .req_kind(req_kind), .req_addr(req_addr),
    .req_page(req_page), .core_addr(core_addr), .core_page(core_page), .core_psen_n(psen_n),
    .core_rd_n(rd_n), .core_wr_n(wr_n));

  mdsec_top i_mdsec_top (.clock(clock), .rst(rst), .ce(ce), .core_addr(core_addr), .core_page(core_page),
    .core_psen_n(psen_n), .core_rd_n(rd_n), .core_wr_n(wr_n), .port_pins(pins), .gl_feedback(fb),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .jtag_cmd_valid(jv), .jtag_cmd(jcmd_c), .jtag_arg(jarg), .jtag_ack(ack), .jtag_refused(refused),
    .jtag_erase_pulse(erase), .jtag_flash_access_en(fl_en), .jtag_debug_en(dbg_en),
    .main_sector_selects(msel), .secondary_segment_selects(ssel), .sram_select(sram_s),
    .regblk_select(regb_s), .main_sector_wr_en(mwe), .secondary_segment_wr_en(swe));

  // Free-running 50 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic close_out();
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Command held for one edge; answer stands only in the following cycle
  task automatic jtag(input logic [2:0] c, input logic [7:0] a, input logic [7:0] exp_ans);
    @(posedge clock);
    jv <= 1'b1;
    jcmd_c <= c;
    jarg <= a;
    @(posedge clock);
    jv <= 1'b0;
    #1 cmp("jtag answer", exp_ans, {5'h0, erase, refused, ack});
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 cmp("register read", exp, rdata);
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Core cycle through the model, selects checked once the model has launched it
  task automatic core(input logic [39:0] r);
    @(posedge clock);
    {req_kind, req_addr, req_page} <= r[39:14];
    @(posedge clock);
    req_kind <= 2'h0;
    #1 cmp("main selects", r[13:6], msel);
    cmp("segment selects", {4'h0, r[5:2]}, {4'h0, ssel});
    cmp("sram and register block", {6'h0, r[1:0]}, {6'h0, sram_s, regb_s});
    we_seen = {swe, mwe};
    @(posedge clock);
  endtask

  // Hang guard, far beyond the roughly 160 cycles the sequence needs
  initial
  begin
    #200us;
    fail_count++;
    close_out();
  end

  initial
  begin
    {fail_count, checked} = '0;
    {rst, ce, reg_wr, reg_rd, jv, jcmd_c, jarg, reg_addr, reg_wdata} = {1'b1, 1'b1, 30'h0};
    {req_kind, req_addr, req_page, pins, fb} = {26'h0, 8'h5a, 8'ha5};
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    core({2'h1, 16'h0000, 8'h00, 14'h0});
    cmp("access enables", 8'h03, {6'h0, fl_en, dbg_en});
    jtag(mdsec_pkg::CMD_PROG_MAP, 8'h00, 8'h01);
    for (i = 0; i < 24; i++)
      core(rows[i]);
    jtag(mdsec_pkg::CMD_PROG_MAIN_PR, 8'h01, 8'h01);
    jtag(mdsec_pkg::CMD_PROG_SEG_PR, 8'h02, 8'h01);
    reg_read(mdsec_pkg::REG_PROT_MAIN, 8'h01);
    reg_write(mdsec_pkg::REG_PROT_MAIN, 8'hfe);
    reg_write(mdsec_pkg::REG_PROT_SEG, 8'h0d);
    reg_read(mdsec_pkg::REG_PROT_MAIN, 8'h01);
    reg_read(mdsec_pkg::REG_PROT_SEG, 8'h02);
    core({2'h3, 16'h0000, 8'h00, 8'h00, 4'h0, 2'h2});
    cmp("main write enable", 8'h00, we_seen[7:0]);
    core({2'h3, 16'ha000, 8'h00, 8'h00, 4'h2, 2'h0});
    cmp("segment write enable", 8'h00, {4'h0, we_seen[11:8]});
    reg_read(mdsec_pkg::REG_VIOL, 8'h03);
    reg_write(mdsec_pkg::REG_VIOL, 8'h03);
    reg_read(mdsec_pkg::REG_VIOL, 8'h00);
    core({2'h3, 16'h4000, 8'h00, 14'h0});
    cmp("main write enable", 8'h02, we_seen[7:0]);
    reg_read(mdsec_pkg::REG_PINS, 8'h5a);
    reg_read(mdsec_pkg::REG_FEEDBACK, 8'ha5);
    reg_read(8'h10, mdsec_pkg::UNMAPPED_RD);
    // Frozen clock enable must swallow a command
    ce <= 1'b0;
    jtag(mdsec_pkg::CMD_SET_SECURITY, 8'h00, 8'h00);
    ce <= 1'b1;
    jtag(mdsec_pkg::CMD_SET_SECURITY, 8'h00, 8'h01);
    cmp("access enables", 8'h00, {6'h0, fl_en, dbg_en});
    for (i = 1; i < 8; i++)
      jtag(i[2:0], 8'hff, 8'h02);
    reg_read(mdsec_pkg::REG_PROT_MAIN, 8'h01);
    jtag(mdsec_pkg::CMD_ERASE_ALL, 8'h00, 8'h05);
    cmp("access enables", 8'h03, {6'h0, fl_en, dbg_en});
    reg_read(mdsec_pkg::REG_STATUS, 8'h00);
    reg_read(mdsec_pkg::REG_PROT_MAIN, mdsec_pkg::PROT_MAIN_RST);
    core({2'h1, 16'h4000, 8'h00, 14'h0});
    jtag(mdsec_pkg::CMD_DEBUG, 8'h00, 8'h01);
    jtag(mdsec_pkg::CMD_FLASH_ACCESS, 8'h00, 8'h01);
    // Second reset in mid-run must blank the loaded map
    jtag(mdsec_pkg::CMD_PROG_MAP, 8'h00, 8'h01);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    core({2'h1, 16'h0000, 8'h00, 14'h0});
    close_out();
  end
endmodule
`default_nettype wire
